// *** rtl/dmbx_params.svh ***
`ifndef DMBX_PARAMS_SVH
`define DMBX_PARAMS_SVH
// execution lengths in core clock cycles
`define DMBX_CYC_ONE   2'h1
`define DMBX_CYC_TWO   2'h2
`define DMBX_CYC_THREE 2'h3
`define DMBX_LAST      2'h0
// fixed register file positions
`define DMBX_R0        5'h00
`define DMBX_R1        5'h01
`define DMBX_PTR_X     5'h1a
`define DMBX_PTR_Y     5'h1c
`define DMBX_PTR_Z     5'h1e
// status bit positions
`define DMBX_F_C       3'h0
`define DMBX_F_Z       3'h1
`define DMBX_F_N       3'h2
`define DMBX_F_V       3'h3
`define DMBX_F_H       3'h5
`define DMBX_F_T       3'h6
// reset values and pointer steps
`define DMBX_STAT_RST  8'h00
`define DMBX_SP_RST    16'h00ff
`define DMBX_STEP_ONE  16'h0001
`define DMBX_STEP_TWO  16'h0002
`endif

// *** rtl/dmbx_pkg.sv ***
`default_nettype none
package dmbx_pkg;
   typedef enum logic [4:0] {
      OP_COPY, OP_PAIR_COPY, OP_LOAD_IMM, OP_LOAD_DIRECT,
      OP_LOAD_INDIRECT, OP_LOAD_DISPLACED, OP_STORE_DIRECT,
      OP_STORE_INDIRECT, OP_STORE_DISPLACED, OP_PROG_READ,
      OP_PROG_WRITE, OP_IO_IN, OP_IO_OUT, OP_PUSH, OP_POP,
      OP_SHIFT_LEFT, OP_SHIFT_RIGHT, OP_ROTATE_LEFT,
      OP_ROTATE_RIGHT, OP_ARITH_RIGHT, OP_SWAP, OP_IO_BIT_SET,
      OP_IO_BIT_CLEAR, OP_BIT_TO_FLAG, OP_FLAG_TO_BIT,
      OP_FLAG_SET, OP_FLAG_CLEAR
   } dmbx_op_e;
   typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z} dmbx_ptr_e;
   typedef enum logic [1:0] {AM_PLAIN, AM_POST, AM_PRE} dmbx_am_e;
   typedef enum logic [1:0] {
      S_IDLE = 2'h1,
      S_BUSY = 2'h2
   } dmbx_fsm_e;
   // one decoded instruction
   typedef struct packed {
      dmbx_op_e   op;
      logic [4:0] rd;
      logic [4:0] rr;
      dmbx_ptr_e  ptr;
      dmbx_am_e   am;
      logic       implied_r0;
      logic [5:0] q;
      logic [15:0] k;
      logic [2:0] b;
   } dmbx_ins_s;
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        we;
      logic        re;
   } dmbx_dm_req_s;
   typedef struct packed {
      logic [15:0] raddr;
      logic        re;
      logic [23:0] waddr;
      logic [15:0] wdata;
      logic        we;
   } dmbx_pm_req_s;
   typedef struct packed {
      logic [5:0] addr;
      logic [7:0] wdata;
      logic       we;
   } dmbx_io_wr_s;
   typedef struct packed {
      dmbx_fsm_e       fsm;
      logic [1:0]      cnt;
      dmbx_ins_s       ins;
      logic [31:0][7:0] rf;
      logic [7:0]      status;
      logic [15:0]     sp;
      dmbx_dm_req_s    dm;
      dmbx_pm_req_s    pm;
      dmbx_io_wr_s     io;
   } dmbx_state_s;
endpackage : dmbx_pkg
`default_nettype wire

// *** rtl/dmbx_core.sv ***
// Overview of operation
// - direct load fetches addressed byte, two cycles
// - direct store writes register, two cycles
// - post-increment load reads then bumps pointer
// - pre-decrement load drops pointer then reads
// - displaced load adds offset, pointer kept
// - displaced store adds offset, pointer kept
// - post-increment store: one cycle via first pair
// - pre-decrement store drops pointer then writes
// - program read into target or r0, three cycles
// - program write of r1:r0, optional step two
// - io transfers take one cycle, flags kept
// - push stores register on stack, two cycles
// - pop loads register from stack, two cycles
// - rotate left through carry with flag update
// - rotate right through carry with flag update
// - io bit set in two cycles
// - io bit clear in two cycles
// - register bit copied into transfer flag
// - transfer flag copied into register bit
// - flag set or clear touches one bit
// - slow data memory adds wait cycles
`timescale 1ns/10ps
`default_nettype none
`include "dmbx_params.svh"
module dmbx_core (
   // clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  nrst,
   // decoded instruction handshake
   input  wire dmbx_pkg::dmbx_ins_s   ins,
   input  wire logic                  ins_valid,
   output logic                       ins_ready,
   // extended page for program writes
   input  wire logic [7:0]            ext_page,
   // data memory
   output dmbx_pkg::dmbx_dm_req_s     dm_req,
   input  wire logic [7:0]            dm_rdata,
   input  wire logic                  dm_wait,
   // program memory
   output dmbx_pkg::dmbx_pm_req_s     pm_req,
   input  wire logic [7:0]            pm_rdata,
   // io space
   output logic                       io_re,
   output logic [5:0]                 io_raddr,
   input  wire logic [7:0]            io_rdata,
   output dmbx_pkg::dmbx_io_wr_s      io_wr,
   // observed core state
   output logic [7:0]                 status_register,
   output logic [15:0]                sp,
   input  wire logic [4:0]            rf_sel,
   output logic [7:0]                 rf_rdata
);
   import dmbx_pkg::*;

   dmbx_state_s s_q;
   dmbx_state_s s_d;
   logic        acc;
   logic [1:0]  cyc;
   logic [4:0]  pidx;
   logic [15:0] pval;
   logic [15:0] ea;
   logic [7:0]  old;
   logic [7:0]  res;
   logic        co;

   ////////////////////////////////////////////////////////////////
   // pointer pair low register index
   function automatic logic [4:0] ptr_lo(input dmbx_ptr_e p);
      case (p)
         PTR_X:   ptr_lo = `DMBX_PTR_X;
         PTR_Y:   ptr_lo = `DMBX_PTR_Y;
         default: ptr_lo = `DMBX_PTR_Z;
      endcase
   endfunction : ptr_lo

   // cycles spent by each instruction
   function automatic logic [1:0] cycles(input dmbx_ins_s i);
      case (i.op)
         OP_LOAD_DIRECT, OP_LOAD_INDIRECT, OP_LOAD_DISPLACED,
         OP_STORE_DIRECT, OP_STORE_DISPLACED, OP_PUSH, OP_POP,
         OP_IO_BIT_SET, OP_IO_BIT_CLEAR:
            cycles = `DMBX_CYC_TWO;
         OP_PROG_READ:
            cycles = `DMBX_CYC_THREE;
         OP_STORE_INDIRECT:
            cycles = (i.ptr == PTR_X && i.am != AM_PRE) ?
                     `DMBX_CYC_ONE : `DMBX_CYC_TWO;
         default:
            cycles = `DMBX_CYC_ONE;
      endcase
   endfunction : cycles

   ////////////////////////////////////////////////////////////////
   // handshake and io read address follow the live instruction
   assign ins_ready = (s_q.fsm == S_IDLE);
   assign acc = ins_valid && ins_ready;
   assign io_raddr = ins.k[5:0];
   assign io_re = acc && (ins.op == OP_IO_IN ||
                  ins.op == OP_IO_BIT_SET || ins.op == OP_IO_BIT_CLEAR);
   assign dm_req = s_q.dm;
   assign pm_req = s_q.pm;
   assign io_wr = s_q.io;
   assign status_register = s_q.status;
   assign sp = s_q.sp;
   assign rf_rdata = s_q.rf[rf_sel];

   ////////////////////////////////////////////////////////////////
   // next state: strobes are single pulses unless a wait holds them
   always_comb begin
      s_d = s_q;
      cyc = cycles(ins);
      pidx = ptr_lo(ins.ptr);
      pval = {s_q.rf[pidx + 5'h01], s_q.rf[pidx]};
      ea = (ins.am == AM_PRE) ? pval - `DMBX_STEP_ONE : pval;
      old = s_q.rf[ins.rd];
      res = old;
      co = s_q.status[`DMBX_F_C];
      s_d.dm.we = 1'h0;
      s_d.dm.re = 1'h0;
      s_d.pm.we = 1'h0;
      s_d.pm.re = 1'h0;
      s_d.io.we = 1'h0;
      if (s_q.fsm == S_BUSY) begin
         if (s_q.cnt != `DMBX_LAST) begin
            s_d.cnt = s_q.cnt - 2'h1;
         end else if (dm_wait && (s_q.dm.re || s_q.dm.we)) begin
            s_d.dm = s_q.dm;
         end else begin
            s_d.fsm = S_IDLE;
            case (s_q.ins.op)
               OP_LOAD_DIRECT, OP_LOAD_INDIRECT,
               OP_LOAD_DISPLACED, OP_POP: begin
                  s_d.rf[s_q.ins.rd] = dm_rdata;
               end
               OP_PROG_READ: begin
                  if (s_q.ins.implied_r0) begin
                     s_d.rf[`DMBX_R0] = pm_rdata;
                  end else begin
                     s_d.rf[s_q.ins.rd] = pm_rdata;
                  end
               end
               default: s_d.fsm = S_IDLE;
            endcase
         end
      end else if (acc) begin
         s_d.ins = ins;
         if (cyc != `DMBX_CYC_ONE) begin
            s_d.fsm = S_BUSY;
            s_d.cnt = cyc - `DMBX_CYC_TWO;
         end
         case (ins.op)
            OP_COPY: s_d.rf[ins.rd] = s_q.rf[ins.rr];
            OP_PAIR_COPY: begin
               s_d.rf[ins.rd] = s_q.rf[ins.rr];
               s_d.rf[ins.rd + 5'h01] = s_q.rf[ins.rr + 5'h01];
            end
            OP_LOAD_IMM: s_d.rf[ins.rd] = ins.k[7:0];
            OP_LOAD_DIRECT, OP_STORE_DIRECT: begin
               s_d.dm.addr = ins.k;
               s_d.dm.wdata = s_q.rf[ins.rr];
               s_d.dm.re = (ins.op == OP_LOAD_DIRECT);
               s_d.dm.we = (ins.op == OP_STORE_DIRECT);
            end
            OP_LOAD_INDIRECT, OP_STORE_INDIRECT: begin
               s_d.dm.addr = ea;
               s_d.dm.wdata = s_q.rf[ins.rr];
               s_d.dm.re = (ins.op == OP_LOAD_INDIRECT);
               s_d.dm.we = (ins.op == OP_STORE_INDIRECT);
               if (ins.am != AM_PLAIN) begin
                  if (ins.am == AM_POST) begin
                     ea = pval + `DMBX_STEP_ONE;
                  end
                  s_d.rf[pidx] = ea[7:0];
                  s_d.rf[pidx + 5'h01] = ea[15:8];
               end
            end
            OP_LOAD_DISPLACED, OP_STORE_DISPLACED: begin
               s_d.dm.addr = pval + {10'h000, ins.q};
               s_d.dm.wdata = s_q.rf[ins.rr];
               s_d.dm.re = (ins.op == OP_LOAD_DISPLACED);
               s_d.dm.we = (ins.op == OP_STORE_DISPLACED);
            end
            OP_PUSH: begin
               s_d.dm.addr = s_q.sp;
               s_d.dm.wdata = s_q.rf[ins.rr];
               s_d.dm.we = 1'h1;
               s_d.sp = s_q.sp - `DMBX_STEP_ONE;
            end
            OP_POP: begin
               s_d.sp = s_q.sp + `DMBX_STEP_ONE;
               s_d.dm.addr = s_d.sp;
               s_d.dm.re = 1'h1;
            end
            OP_PROG_READ: begin
               s_d.pm.raddr = {s_q.rf[`DMBX_PTR_Z + 5'h01],
                               s_q.rf[`DMBX_PTR_Z]};
               s_d.pm.re = 1'h1;
               if (ins.am == AM_POST) begin
                  ea = s_d.pm.raddr + `DMBX_STEP_ONE;
                  s_d.rf[`DMBX_PTR_Z] = ea[7:0];
                  s_d.rf[`DMBX_PTR_Z + 5'h01] = ea[15:8];
               end
            end
            OP_PROG_WRITE: begin
               ea = {s_q.rf[`DMBX_PTR_Z + 5'h01],
                     s_q.rf[`DMBX_PTR_Z]};
               s_d.pm.waddr = {ext_page, ea};
               s_d.pm.wdata = {s_q.rf[`DMBX_R1], s_q.rf[`DMBX_R0]};
               s_d.pm.we = 1'h1;
               if (ins.am == AM_POST) begin
                  ea = ea + `DMBX_STEP_TWO;
                  s_d.rf[`DMBX_PTR_Z] = ea[7:0];
                  s_d.rf[`DMBX_PTR_Z + 5'h01] = ea[15:8];
               end
            end
            OP_IO_IN: s_d.rf[ins.rd] = io_rdata;
            OP_IO_OUT: begin
               s_d.io.addr = ins.k[5:0];
               s_d.io.wdata = s_q.rf[ins.rr];
               s_d.io.we = 1'h1;
            end
            OP_IO_BIT_SET, OP_IO_BIT_CLEAR: begin
               // read now, write back next cycle
               s_d.io.addr = ins.k[5:0];
               s_d.io.wdata = io_rdata;
               s_d.io.wdata[ins.b] =
                  (ins.op == OP_IO_BIT_SET);
               s_d.io.we = 1'h1;
            end
            OP_SHIFT_LEFT, OP_ROTATE_LEFT, OP_SHIFT_RIGHT,
            OP_ROTATE_RIGHT, OP_ARITH_RIGHT: begin
               if (ins.op == OP_SHIFT_LEFT ||
                   ins.op == OP_ROTATE_LEFT) begin
                  res = {old[6:0],
                         co && ins.op == OP_ROTATE_LEFT};
                  co = old[7];
                  s_d.status[`DMBX_F_H] = old[3];
               end else begin
                  res = {(ins.op == OP_ROTATE_RIGHT) ? co :
                         (ins.op == OP_ARITH_RIGHT) && old[7],
                         old[7:1]};
                  co = old[0];
               end
               s_d.rf[ins.rd] = res;
               s_d.status[`DMBX_F_C] = co;
               s_d.status[`DMBX_F_Z] = (res == 8'h00);
               s_d.status[`DMBX_F_N] = res[7];
               s_d.status[`DMBX_F_V] = res[7] ^ co;
            end
            OP_SWAP: s_d.rf[ins.rd] = {old[3:0], old[7:4]};
            OP_BIT_TO_FLAG: begin
               s_d.status[`DMBX_F_T] = s_q.rf[ins.rr][ins.b];
            end
            OP_FLAG_TO_BIT: begin
               s_d.rf[ins.rd][ins.b] = s_q.status[`DMBX_F_T];
            end
            OP_FLAG_SET: s_d.status[ins.b] = 1'h1;
            OP_FLAG_CLEAR: s_d.status[ins.b] = 1'h0;
            default: s_d.fsm = S_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // state register; X/Y/Z pointers and registers start cleared, stack pointer starts at 00ff
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         s_q <= '0;
         s_q.fsm <= S_IDLE;
         s_q.status <= `DMBX_STAT_RST;
         s_q.sp <= `DMBX_SP_RST;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   AST_DIRECT_LOAD: assert property (
      acc && ins.op == OP_LOAD_DIRECT |=> s_q.dm.re &&
      s_q.dm.addr == $past(ins.k) && !ins_ready &&
      s_q.status == $past(s_q.status))
      else $error("direct load request wrong");
   AST_DIRECT_STORE: assert property (
      acc && ins.op == OP_STORE_DIRECT |=> s_q.dm.we &&
      s_q.dm.wdata == $past(s_q.rf[ins.rr]) && !ins_ready)
      else $error("direct store request wrong");
   AST_POST_INC: assert property (
      acc && ins.op == OP_LOAD_INDIRECT && ins.am == AM_POST
      |=> {s_q.rf[`DMBX_PTR_X + 5'h01], s_q.rf[`DMBX_PTR_X]}
      == s_q.dm.addr + `DMBX_STEP_ONE || $past(ins.ptr) != PTR_X)
      else $error("post increment pointer wrong");
   AST_PRE_DEC: assert property (
      acc && ins.op == OP_LOAD_INDIRECT && ins.am == AM_PRE &&
      ins.ptr == PTR_Y |=> s_q.dm.addr == {s_q.rf[`DMBX_PTR_Y +
      5'h01], s_q.rf[`DMBX_PTR_Y]} && s_q.dm.addr ==
      $past(pval) - `DMBX_STEP_ONE)
      else $error("pre decrement address wrong");
   AST_DISPLACED: assert property (
      acc && ins.op == OP_LOAD_DISPLACED |=> s_q.dm.addr ==
      $past(pval) + {10'h000, $past(ins.q)} && $stable(s_q.rf))
      else $error("displaced address wrong");
   AST_FAST_STORE: assert property (
      acc && ins.op == OP_STORE_INDIRECT && ins.ptr == PTR_X &&
      ins.am != AM_PRE |=> ins_ready && s_q.dm.we)
      else $error("first pair store not single cycle");
   AST_PROG_READ: assert property (
      acc && ins.op == OP_PROG_READ |=> !ins_ready ##1
      !ins_ready ##1 ins_ready)
      else $error("program read not three cycles");
   AST_IO_IN: assert property (
      acc && ins.op == OP_IO_IN |=> ins_ready &&
      s_q.rf[$past(ins.rd)] == $past(io_rdata) &&
      s_q.status == $past(s_q.status))
      else $error("io read wrong");
   AST_PUSH: assert property (
      acc && ins.op == OP_PUSH |=> s_q.sp == $past(s_q.sp) -
      `DMBX_STEP_ONE && s_q.dm.addr == $past(s_q.sp))
      else $error("push stack wrong");
   AST_ROTATE: assert property (
      acc && ins.op == OP_ROTATE_LEFT |=> s_q.status[`DMBX_F_C]
      == $past(old[7]) && s_q.rf[$past(ins.rd)][0] ==
      $past(s_q.status[`DMBX_F_C]))
      else $error("rotate left wrong");
   AST_BIT_SET: assert property (
      acc && ins.op == OP_IO_BIT_SET |=> s_q.io.we &&
      s_q.io.wdata == ($past(io_rdata) | (8'h01 << $past(ins.b)))
      && !ins_ready ##1 ins_ready)
      else $error("io bit set wrong");
   AST_FLAG_SET: assert property (
      acc && ins.op == OP_FLAG_SET |=> s_q.status ==
      ($past(s_q.status) | (8'h01 << $past(ins.b))))
      else $error("flag set touched other bits");
   AST_WAIT: assert property (
      s_q.fsm == S_BUSY && s_q.cnt == `DMBX_LAST && dm_wait &&
      s_q.dm.re |=> s_q.fsm == S_BUSY && s_q.dm.re)
      else $error("wait did not stretch access");
endmodule : dmbx_core
`default_nettype wire

// *** dv/dmbx_mem_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module dmbx_mem_model (
   // clock and stall control
   input  wire logic                   clk_sys,
   input  wire logic                   slow,
   // data memory
   input  wire dmbx_pkg::dmbx_dm_req_s dm_req,
   output logic [7:0]                  dm_rdata,
   output logic                        dm_wait,
   // program memory
   input  wire dmbx_pkg::dmbx_pm_req_s pm_req,
   output logic [7:0]                  pm_rdata,
   // io space
   input  wire logic                   io_re,
   input  wire logic [5:0]             io_raddr,
   output logic [7:0]                  io_rdata,
   input  wire dmbx_pkg::dmbx_io_wr_s  io_wr
);
   import dmbx_pkg::*;
   logic [7:0]  dm [65536];
   logic [7:0]  io [64];
   logic [7:0]  junk_q = 8'h5a;
   logic        waited_q = 1'b0;
   logic [1:0]  pcnt_q = 2'h0;
   logic [15:0] paddr_q;
   logic [23:0] pw_addr;
   logic [15:0] pw_data;

   // known fill so the bench can predict every load
   initial begin
      for (int i = 0; i < 65536; i++)
         dm[i] = 8'(i * 7 + 3);
      for (int i = 0; i < 64; i++)
         io[i] = 8'(i * 5 + 1);
   end
   ////////////////////////////////////////////////////////////////////////
   // a slow memory holds off the first cycle of each read
   assign dm_wait  = slow && dm_req.re && !waited_q;
   // idle lines show a moving pattern, so a stale capture is caught
   assign dm_rdata = (dm_req.re && !dm_wait) ? dm[dm_req.addr] : junk_q;
   assign io_rdata = io_re ? io[io_raddr] : junk_q;
   assign pm_rdata = (pcnt_q != 2'h0) ?
                     (paddr_q[7:0] ^ paddr_q[15:8] ^ 8'h3c) : junk_q;

   // writes land at the edge; program data lasts two cycles after a read
   always @(posedge clk_sys) begin
      junk_q   <= junk_q + 8'h3b;
      waited_q <= dm_wait;
      pcnt_q   <= pm_req.re ? 2'h2 : pcnt_q - {1'b0, pcnt_q != 2'h0};
      if (pm_req.re)
         paddr_q <= pm_req.raddr;
      if (pm_req.we) begin
         pw_addr <= pm_req.waddr;
         pw_data <= pm_req.wdata;
      end
      if (dm_req.we)
         dm[dm_req.addr] <= dm_req.wdata;
      if (io_wr.we)
         io[io_wr.addr] <= io_wr.wdata;
   end
endmodule : dmbx_mem_model
`default_nettype wire

// *** dv/data_move_bit_instr_exec_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module data_move_bit_instr_exec_tb;
   import dmbx_pkg::*;
   logic         clk_sys = 1'b0;
   logic         nrst = 1'b0;
   dmbx_ins_s    ins = '0;
   logic         ins_valid = 1'b0;
   logic         ins_ready;
   logic [7:0]   ext_page = 8'h00;
   dmbx_dm_req_s dm_req;
   logic [7:0]   dm_rdata, pm_rdata, io_rdata, rf_rdata, status_register;
   logic         dm_wait, io_re;
   dmbx_pm_req_s pm_req;
   logic [5:0]   io_raddr;
   dmbx_io_wr_s  io_wr;
   logic [15:0]  sp;
   logic [4:0]   rf_sel = 5'h00;
   logic         slow = 1'b0;
   int           fail_count = 0;
   int           total_checks = 0;
   logic [7:0]   exp_sr = 8'h00;
   logic [15:0]  exp_sp = 16'h00ff;
   logic [15:0]  a, p;
   logic [7:0]   v, w, e;
   logic [5:0]   q;
   logic [2:0]   b;
   dmbx_ins_s    t;
   dmbx_op_e     shops[6] = '{OP_ROTATE_LEFT, OP_ROTATE_RIGHT, OP_SHIFT_LEFT,
                              OP_SHIFT_RIGHT, OP_ARITH_RIGHT, OP_SWAP};

   always #5 clk_sys = ~clk_sys;

   dmbx_core i_dmbx_core (.clk_sys, .nrst, .ins, .ins_valid, .ins_ready,
      .ext_page, .dm_req, .dm_rdata, .dm_wait, .pm_req, .pm_rdata, .io_re,
      .io_raddr, .io_rdata, .io_wr, .status_register, .sp, .rf_sel,
      .rf_rdata);
   dmbx_mem_model i_dmbx_mem_model (.clk_sys, .slow, .dm_req, .dm_rdata,
      .dm_wait, .pm_req, .pm_rdata, .io_re, .io_raddr, .io_rdata, .io_wr);
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(string nm, logic [23:0] seen, logic [23:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic end_of_test();
      if (fail_count == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_of_test

   function automatic logic [7:0] mem(logic [15:0] ad);
      return i_dmbx_mem_model.dm[ad];
   endfunction : mem

   function automatic logic [7:0] iom(logic [5:0] ad);
      return i_dmbx_mem_model.io[ad];
   endfunction : iom

   function automatic logic [4:0] pb(dmbx_ptr_e pt);
      return 5'h1a + {2'h0, pt, 1'b0};
   endfunction : pb

   function automatic dmbx_ins_s mk(dmbx_op_e op, logic [4:0] rd,
         logic [15:0] k = 16'h0000, dmbx_ptr_e pt = PTR_X,
         dmbx_am_e am = AM_PLAIN, logic [5:0] qq = 6'h00,
         logic [2:0] bb = 3'h0);
      dmbx_ins_s i;
      i = '0;
      i.op = op;
      i.rd = rd;
      i.rr = rd;
      i.k = k;
      i.ptr = pt;
      i.am = am;
      i.q = qq;
      i.b = bb;
      return i;
   endfunction : mk

   // expected shift result; carry, zero, negative, overflow follow, half only on left shifts, swap keeps flags
   function automatic logic [7:0] shf(dmbx_op_e op, logic [7:0] x);
      logic [7:0] r;
      logic       c;
      c = x[0];
      case (op)
         OP_ROTATE_LEFT:  r = {x[6:0], exp_sr[0]};
         OP_SHIFT_LEFT:   r = {x[6:0], 1'b0};
         OP_ROTATE_RIGHT: r = {exp_sr[0], x[7:1]};
         OP_SHIFT_RIGHT:  r = {1'b0, x[7:1]};
         OP_ARITH_RIGHT:  r = {x[7], x[7:1]};
         default:         return {x[3:0], x[7:4]};
      endcase
      if (op == OP_ROTATE_LEFT || op == OP_SHIFT_LEFT) begin
         c = x[7];
         exp_sr[5] = x[3];
      end
      exp_sr[0] = c;
      exp_sr[1] = (r == 8'h00);
      exp_sr[2] = r[7];
      exp_sr[3] = r[7] ^ c;
      return r;
   endfunction : shf

   // one instruction: offer, count cycles until ready, check flags
   task automatic run(dmbx_ins_s i, int cyc);
      int n;
      @(posedge clk_sys);
      ins <= i;
      ins_valid <= 1'b1;
      @(posedge clk_sys);
      ins_valid <= 1'b0;
      #1;
      n = 1;
      while (ins_ready !== 1'b1 && n < 20) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      // posted writes land at the edge after their strobe
      @(posedge clk_sys);
      #1;
      chk("cycles", 24'(n), 24'(cyc));
      chk("status", 24'(status_register), 24'(exp_sr));
   endtask : run

   task automatic chr(string nm, logic [4:0] r, logic [7:0] ex);
      logic [7:0] o;
      @(posedge clk_sys);
      rf_sel <= r;
      #1;
      o = rf_rdata;
      chk(nm, 24'(o), 24'(ex));
   endtask : chr

   task automatic imm(logic [4:0] r, logic [7:0] val);
      run(mk(OP_LOAD_IMM, r, 16'(val)), 1);
   endtask : imm

   task automatic setp(dmbx_ptr_e pt, logic [15:0] val);
      imm(pb(pt), val[7:0]);
      imm(pb(pt) + 5'h1, val[15:8]);
   endtask : setp

   task automatic chp(dmbx_ptr_e pt, logic [15:0] ex);
      chr("pointer_lo", pb(pt), ex[7:0]);
      chr("pointer_hi", pb(pt) + 5'h1, ex[15:8]);
   endtask : chp

   task automatic fl(int f, logic val);
      exp_sr[f] = val;
      run(mk(val ? OP_FLAG_SET : OP_FLAG_CLEAR, 5'h00, 16'h0, PTR_X,
             AM_PLAIN, 6'h00, 3'(f)), 1);
   endtask : fl

   // pointer access: address and pointer update worked out per mode
   task automatic ind(dmbx_op_e op, dmbx_ptr_e pt, dmbx_am_e am, int cyc);
      logic [15:0] ad;
      logic        disp;
      p = 16'($urandom);
      v = 8'($urandom);
      disp = (op == OP_LOAD_DISPLACED || op == OP_STORE_DISPLACED);
      q = disp ? 6'($urandom) : 6'h00;
      ad = (am == AM_PRE) ? p - 16'h1 : p + 16'(q);
      imm(5'd2, v);
      setp(pt, p);
      w = mem(ad);
      run(mk(op, 5'd2, 16'h0, pt, am, q), cyc);
      if (op == OP_LOAD_INDIRECT || op == OP_LOAD_DISPLACED)
         chr("load_data", 5'd2, w);
      else
         chk("store_data", 24'(mem(ad)), 24'(v));
      chp(pt, am == AM_POST ? p + 16'h1 : (am == AM_PRE ? ad : p));
   endtask : ind
   ////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'hf112));
      repeat (16) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (4) begin
         a = 16'($urandom);
         w = mem(a);
         run(mk(OP_LOAD_DIRECT, 5'd3, a), 2);
         chr("load_direct", 5'd3, w);
         v = 8'($urandom);
         imm(5'd4, v);
         run(mk(OP_STORE_DIRECT, 5'd4, ~a), 2);
         chk("store_direct", 24'(mem(~a)), 24'(v));
         // a stalled memory stretches the load by one cycle
         @(posedge clk_sys);
         slow <= 1'b1;
         w = mem(a + 16'h1);
         run(mk(OP_LOAD_DIRECT, 5'd3, a + 16'h1), 3);
         @(posedge clk_sys);
         slow <= 1'b0;
         chr("load_slow", 5'd3, w);
         ind(OP_LOAD_INDIRECT, PTR_X, AM_POST, 2);
         ind(OP_LOAD_INDIRECT, PTR_Y, AM_PRE, 2);
         ind(OP_LOAD_DISPLACED, PTR_Z, AM_PLAIN, 2);
         ind(OP_STORE_DISPLACED, PTR_Y, AM_PLAIN, 2);
         ind(OP_STORE_INDIRECT, PTR_X, AM_POST, 1);
         ind(OP_STORE_INDIRECT, PTR_Z, AM_POST, 2);
         ind(OP_STORE_INDIRECT, PTR_Z, AM_PRE, 2);
         p = 16'($urandom);
         setp(PTR_Z, p);
         run(mk(OP_PROG_READ, 5'd6, 16'h0, PTR_Z, AM_POST), 3);
         chr("prog_read", 5'd6, p[7:0] ^ p[15:8] ^ 8'h3c);
         p++;
         chp(PTR_Z, p);
         t = mk(OP_PROG_READ, 5'd6, 16'h0, PTR_Z);
         t.implied_r0 = 1'b1;
         run(t, 3);
         chr("prog_read_r0", 5'd0, p[7:0] ^ p[15:8] ^ 8'h3c);
         v = 8'($urandom);
         w = 8'($urandom);
         e = 8'($urandom);
         imm(5'd0, v);
         imm(5'd1, w);
         @(posedge clk_sys);
         ext_page <= e;
         run(mk(OP_PROG_WRITE, 5'd0, 16'h0, PTR_Z, AM_POST), 1);
         chk("prog_waddr", i_dmbx_mem_model.pw_addr, {e, p});
         chk("prog_wdata", 24'(i_dmbx_mem_model.pw_data),
             {8'h0, w, v});
         chp(PTR_Z, p + 16'h2);
         q = 6'($urandom);
         imm(5'd7, v);
         run(mk(OP_IO_OUT, 5'd7, 16'(q)), 1);
         chk("io_out", 24'(iom(q)), 24'(v));
         w = iom(~q);
         run(mk(OP_IO_IN, 5'd8, 16'(~q)), 1);
         chr("io_in", 5'd8, w);
         b = 3'($urandom);
         t = mk(OP_IO_BIT_SET, 5'd0, 16'(q), PTR_X, AM_PLAIN, 6'h0, b);
         run(t, 2);
         v = v | (8'h1 << b);
         chk("io_bit_set", 24'(iom(q)), 24'(v));
         t.op = OP_IO_BIT_CLEAR;
         t.b = ~b;
         run(t, 2);
         chk("io_bit_clear", 24'(iom(q)), 24'(v & ~(8'h1 << ~b)));
         imm(5'd9, v);
         run(mk(OP_PUSH, 5'd9), 2);
         chk("push_data", 24'(mem(exp_sp)), 24'(v));
         exp_sp--;
         chk("push_sp", 24'(sp), 24'(exp_sp));
         run(mk(OP_POP, 5'd10), 2);
         exp_sp++;
         chr("pop_data", 5'd10, v);
         chk("pop_sp", 24'(sp), 24'(exp_sp));
         imm(5'd11, v);
         // bit b was just forced high, so a random bit is copied instead
         exp_sr[6] = v[~b];
         t = mk(OP_BIT_TO_FLAG, 5'd11, 16'h0, PTR_X, AM_PLAIN, 6'h0, ~b);
         run(t, 1);
         imm(5'd12, w);
         w[b] = v[~b];
         t = mk(OP_FLAG_TO_BIT, 5'd12, 16'h0, PTR_X, AM_PLAIN, 6'h0, b);
         run(t, 1);
         chr("flag_to_bit", 5'd12, w);
         for (int f = 0; f < 8; f++) begin
            fl(f, 1'b1);
            fl(f, 1'b0);
            fl(f, 1'($urandom));
         end
         foreach (shops[j]) begin
            v = 8'($urandom);
            imm(5'd13, v);
            w = shf(shops[j], v);
            run(mk(shops[j], 5'd13), 1);
            chr("shift_result", 5'd13, w);
         end
         imm(5'd14, v);
         imm(5'd15, w);
         t = mk(OP_PAIR_COPY, 5'd16);
         t.rr = 5'd14;
         run(t, 1);
         chr("pair_lo", 5'd16, v);
         chr("pair_hi", 5'd17, w);
         t = mk(OP_COPY, 5'd18);
         t.rr = 5'd15;
         run(t, 1);
         chr("copy", 5'd18, w);
      end
      end_of_test();
   end

   // hang guard, far beyond the roughly 1340 cycles the tests need
   initial begin
      repeat (20000) @(posedge clk_sys);
      fail_count++;
      end_of_test();
   end
endmodule : data_move_bit_instr_exec_tb
`default_nettype wire
